// >>> include/srm_pkg.sv
package srm_pkg;
   // ************************************************
   // stream framing
   // ************************************************
   localparam int PRE_W = 6;
   localparam logic [5:0] PREAMBLE = 6'h3E;
   localparam int CRC_W = 11;
   localparam int TAIL_W = 12;
   localparam logic [3:0] TAIL_LAST = 4'hB;
   localparam int CNT_W = 21;
   // data bits between preamble and tail: 399,630 / 841,350 / 1,445,502
   localparam logic [20:0] SKIP_SMALL = 21'h06190E;
   localparam logic [20:0] SKIP_MID = 21'h0CD686;
   localparam logic [20:0] SKIP_LARGE = 21'h160E7E;
   localparam logic [1:0] SIZE_SMALL = 2'h0;
   localparam logic [1:0] SIZE_MID = 2'h1;
   // ************************************************
   // buffering and duplicate logic
   // ************************************************
   localparam int FIFO_DEPTH = 8;
   localparam int N_DUP = 4;
   localparam logic [7:0] CHK_CNT_RST = 8'h00;
   // ************************************************
   // link state machine
   // ************************************************
   typedef enum logic [2:0] {
      LNK_SEARCH = 3'h1,
      LNK_SKIP = 3'h2,
      LNK_TAIL = 3'h4
   } srm_lnk_state_t;
endpackage

// >>> rtl/srm_fifo.sv
`timescale 1ns/1ns
module srm_fifo
   import srm_pkg::*;
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_data <= '0;
      end else begin
         out_data <= mem_r[pop ? rd_r + AW'(1) : rd_r];
         if (push && (cnt_r == '0 || (pop && cnt_r == (AW+1)'(1)))) begin
            out_data <= in_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= wr_r + AW'(1);
         end
         if (pop) begin
            rd_r <= rd_r + AW'(1);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_r <= cnt_r - (AW+1)'(1);
         end
      end
   end
endmodule

// >>> rtl/srm_monitor.sv
`timescale 1ns/1ns
// Overview of operation
// - frame starts only after five ones then one zero
// - skip a size-dependent count of data bits after the preamble
// - tail is a zero bit then eleven checksum bits; keep the eleven
// - compare captured checksum with expected one; difference means possible upset
// - mismatch raises the upset alarm, usable as processor interrupt
// - stream carries one bit per readback clock, all flops and config bits
// - readback runs in the background, user logic untouched
// - checksum over all read bits is appended at stream end
// - readback source is either an external pin or an internal signal
// - each duplicate copy XORs with its primary, one on disagreement
// - all XOR outputs are ORed into one upset status bit
// - upset status may float every user output
// - outputs stay floated until configuration is reported loaded on cfg_done
// - two comparators in parallel; only agreeing errors count as upset
module srm_monitor
   import srm_pkg::*;
#(
   parameter logic [20:0] SKIP_SMALL_P = SKIP_SMALL,
   parameter logic [20:0] SKIP_MID_P = SKIP_MID,
   parameter logic [20:0] SKIP_LARGE_P = SKIP_LARGE
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // readback link
   input wire logic rb_clk,
   input wire logic rb_pin_data,
   input wire logic rb_int_data,
   input wire logic rb_src_sel,
   input wire logic [1:0] dev_size,
   // checker control
   input wire logic [CRC_W-1:0] exp_crc,
   input wire logic chk_en,
   input wire logic reconfig,
   input wire logic cfg_done,
   input wire logic float_en,
   // duplicate-logic pairs
   input wire logic [N_DUP-1:0] dup_primary,
   input wire logic [N_DUP-1:0] dup_copy,
   // status
   output logic upset_alarm,
   output logic upset_status,
   output logic global_output_float,
   output logic cmp_fault,
   output logic check_done,
   output logic [CRC_W-1:0] crc_last,
   output logic [7:0] check_count,
   output logic rb_overrun,
   output logic rb_frame_err
);
   // ************************************************
   // link domain reset release
   // ************************************************
   logic lrst_s1;
   logic lrst_n;

   always_ff @(posedge rb_clk or negedge rstn) begin
      if (!rstn) begin
         lrst_s1 <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_s1 <= 1'b1;
         lrst_n <= lrst_s1;
      end
   end

   // ************************************************
   // link input synchronisers
   // ************************************************
   logic sel_s1;
   logic sel_s2;
   logic [1:0] size_s1;
   logic [1:0] size_s2;
   logic rb_s1;
   logic rb_bit;
   logic ack_s1;
   logic ack_s2;
   logic seen_r;

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         sel_s1 <= 1'b0;
         sel_s2 <= 1'b0;
         size_s1 <= 2'h0;
         size_s2 <= 2'h0;
      end else begin
         sel_s1 <= rb_src_sel;
         sel_s2 <= sel_s1;
         size_s1 <= dev_size;
         size_s2 <= size_s1;
      end
   end

   // either source feeds one synchroniser, so switching costs no extra logic
   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rb_s1 <= 1'b0;
         rb_bit <= 1'b0;
      end else begin
         rb_s1 <= sel_s2 ? rb_int_data : rb_pin_data;
         rb_bit <= rb_s1;
      end
   end

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= seen_r;
         ack_s2 <= ack_s1;
      end
   end

   // ************************************************
   // frame parser
   // ************************************************
   srm_lnk_state_t st_r;
   srm_lnk_state_t st_nxt;
   logic [PRE_W-1:0] pre_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] skip_last;
   logic [3:0] tcnt_r;
   logic [TAIL_W-1:0] tail_r;
   logic [TAIL_W-1:0] tail_full;
   logic pre_hit;
   logic skip_end;
   logic tail_end;

   // end count picked per device size
   always_comb begin
      case (size_s2)
         SIZE_SMALL: skip_last = SKIP_SMALL_P - CNT_W'(1);
         SIZE_MID: skip_last = SKIP_MID_P - CNT_W'(1);
         default: skip_last = SKIP_LARGE_P - CNT_W'(1);
      endcase
   end

   // one stream bit per link edge; the rate limits are the driver's job
   assign pre_hit = ({pre_r[PRE_W-2:0], rb_bit} == PREAMBLE);
   assign skip_end = (cnt_r == skip_last);
   assign tail_end = (tcnt_r == TAIL_LAST);
   assign tail_full = {tail_r[TAIL_W-2:0], rb_bit};

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         LNK_SEARCH: begin
            if (pre_hit) begin
               st_nxt = LNK_SKIP;
            end
         end
         LNK_SKIP: begin
            if (skip_end) begin
               st_nxt = LNK_TAIL;
            end
         end
         LNK_TAIL: begin
            if (tail_end) begin
               st_nxt = LNK_SEARCH;
            end
         end
         default: st_nxt = LNK_SEARCH;
      endcase
   end

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         st_r <= LNK_SEARCH;
      end else begin
         st_r <= st_nxt;
      end
   end

   // preamble window cleared outside search so stale tail bits never match
   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         pre_r <= '0;
      end else if (st_r == LNK_SEARCH && !pre_hit) begin
         pre_r <= {pre_r[PRE_W-2:0], rb_bit};
      end else begin
         pre_r <= '0;
      end
   end

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         cnt_r <= '0;
      end else if (st_r == LNK_SKIP && !skip_end) begin
         cnt_r <= cnt_r + CNT_W'(1);
      end else begin
         cnt_r <= '0;
      end
   end

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         tcnt_r <= 4'h0;
         tail_r <= '0;
      end else if (st_r == LNK_TAIL && !tail_end) begin
         tcnt_r <= tcnt_r + 4'h1;
         tail_r <= tail_full;
      end else begin
         tcnt_r <= 4'h0;
         tail_r <= '0;
      end
   end

   // ************************************************
   // link side of the word handshake
   // ************************************************
   logic [CRC_W-1:0] cap_word_r;
   logic req_tgl_r;
   logic ovr_r;
   logic ferr_r;
   logic cap;
   logic slot_free;

   // the stream cannot be paused, so a word that finds the slot busy is lost
   assign cap = (st_r == LNK_TAIL) && tail_end;
   assign slot_free = (ack_s2 == req_tgl_r);

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         cap_word_r <= '0;
         req_tgl_r <= 1'b0;
      end else if (cap && slot_free) begin
         cap_word_r <= tail_full[CRC_W-1:0];
         req_tgl_r <= ~req_tgl_r;
      end
   end

   always_ff @(posedge rb_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ovr_r <= 1'b0;
         ferr_r <= 1'b0;
      end else begin
         if (cap && !slot_free) begin
            ovr_r <= 1'b1;
         end
         if (cap && tail_full[TAIL_W-1]) begin
            ferr_r <= 1'b1;
         end
      end
   end

   // ************************************************
   // core side synchronisers
   // ************************************************
   logic req_s1;
   logic req_s2;
   logic ovr_s1;
   logic ferr_s1;
   logic cfg_s1;
   logic cfg_s2;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         ovr_s1 <= 1'b0;
         rb_overrun <= 1'b0;
         ferr_s1 <= 1'b0;
         rb_frame_err <= 1'b0;
         cfg_s1 <= 1'b0;
         cfg_s2 <= 1'b0;
      end else begin
         req_s1 <= req_tgl_r;
         req_s2 <= req_s1;
         ovr_s1 <= ovr_r;
         rb_overrun <= ovr_s1;
         ferr_s1 <= ferr_r;
         rb_frame_err <= ferr_s1;
         cfg_s1 <= cfg_done;
         cfg_s2 <= cfg_s1;
      end
   end

   // ************************************************
   // checksum buffer
   // ************************************************
   logic f_in_ready;
   logic f_out_valid;
   logic [CRC_W-1:0] f_out_data;
   logic push;
   logic pop;

   // full buffer holds the toggle unacknowledged, stalling the link slot
   assign push = (req_s2 != seen_r);
   assign pop = f_out_valid & chk_en;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         seen_r <= 1'b0;
      end else if (push && f_in_ready) begin
         seen_r <= req_s2;
      end
   end

   srm_fifo #(
      .WIDTH(CRC_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(core_clk),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(f_in_ready),
      .in_data(cap_word_r),
      .out_valid(f_out_valid),
      .out_ready(chk_en),
      .out_data(f_out_data)
   );

   // ************************************************
   // dual checksum comparators
   // ************************************************
   logic mis_a_r;
   logic mis_b_r;
   logic cmp_vld_r;
   logic alarm_set;

   // second copy uses a different form so one upset cannot hit both alike
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mis_a_r <= 1'b0;
         mis_b_r <= 1'b0;
         cmp_vld_r <= 1'b0;
         crc_last <= '0;
      end else begin
         cmp_vld_r <= pop;
         if (pop) begin
            mis_a_r <= (f_out_data != exp_crc);
            mis_b_r <= |(f_out_data ^ exp_crc);
            crc_last <= f_out_data;
         end
      end
   end

   assign alarm_set = cmp_vld_r & mis_a_r & mis_b_r;

   // set wins over the reconfigure clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         upset_alarm <= 1'b0;
      end else if (alarm_set) begin
         upset_alarm <= 1'b1;
      end else if (reconfig) begin
         upset_alarm <= 1'b0;
      end
   end

   // comparators disagreeing points at the monitor itself, not the config
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cmp_fault <= 1'b0;
      end else if (cmp_vld_r && (mis_a_r != mis_b_r)) begin
         cmp_fault <= 1'b1;
      end else if (reconfig) begin
         cmp_fault <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         check_done <= 1'b0;
         check_count <= CHK_CNT_RST;
      end else begin
         check_done <= cmp_vld_r;
         if (cmp_vld_r) begin
            check_count <= check_count + 8'h01;
         end
      end
   end

   // ************************************************
   // duplicate logic compare and output float
   // ************************************************
   logic [N_DUP-1:0] dup_diff;
   logic dup_any;
   logic io_ok_r;

   assign dup_diff = dup_primary ^ dup_copy;
   assign dup_any = |dup_diff;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         upset_status <= 1'b0;
      end else if (dup_any) begin
         upset_status <= 1'b1;
      end else if (reconfig) begin
         upset_status <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         io_ok_r <= 1'b0;
      end else if (reconfig) begin
         io_ok_r <= 1'b0;
      end else if (cfg_s2) begin
         io_ok_r <= 1'b1;
      end
   end

   // float is driven from the live xor too, so it acts a cycle earlier
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         global_output_float <= 1'b1;
      end else begin
         global_output_float <= !io_ok_r || reconfig || (float_en && (dup_any || upset_status));
      end
   end
endmodule

// >>> tb/seu_readback_crc_monitor_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin \
   n_checks++; \
   if ((a) !== (b)) begin \
      fails++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); \
   end \
end
module seu_readback_crc_monitor_tb_top
   import srm_pkg::*;
;
   localparam logic [20:0] SK0 = 21'h000010;
   localparam logic [20:0] SK1 = 21'h000020;
   localparam logic [20:0] SK2 = 21'h000030;
   typedef struct {
      logic [1:0] size;
      logic sel;
      logic [CRC_W-1:0] crc;
      logic [CRC_W-1:0] exp;
      logic alarm;
   } srm_row_t;
   srm_row_t rows [5] = '{
      '{2'h0, 1'b0, 11'h5A3, 11'h5A3, 1'b0},
      '{2'h1, 1'b1, 11'h7FF, 11'h7FE, 1'b1},
      '{2'h2, 1'b0, 11'h400, 11'h400, 1'b0},
      '{2'h3, 1'b1, 11'h001, 11'h001, 1'b0},
      '{2'h0, 1'b1, 11'h2C7, 11'h6C7, 1'b1}};
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic rb_clk, rb_pin_data, rb_int_data;
   logic rb_src_sel = 1'b0;
   logic [1:0] dev_size = 2'h0;
   logic [CRC_W-1:0] exp_crc = 11'h000;
   logic chk_en = 1'b0, reconfig = 1'b0, cfg_done = 1'b0, float_en = 1'b0;
   logic [N_DUP-1:0] dup_primary = 4'h0, dup_copy = 4'h0;
   logic upset_alarm, upset_status, global_output_float, cmp_fault, check_done;
   logic [CRC_W-1:0] crc_last;
   logic [7:0] check_count;
   logic rb_overrun, rb_frame_err;
   int fails = 0, n_checks = 0, ndone;
   always #5 core_clk = ~core_clk;
   srm_monitor #(.SKIP_SMALL_P(SK0), .SKIP_MID_P(SK1), .SKIP_LARGE_P(SK2)) DUT (
      .core_clk, .rstn, .rb_clk, .rb_pin_data, .rb_int_data, .rb_src_sel, .dev_size,
      .exp_crc, .chk_en, .reconfig, .cfg_done, .float_en, .dup_primary, .dup_copy,
      .upset_alarm, .upset_status, .global_output_float, .cmp_fault, .check_done,
      .crc_last, .check_count, .rb_overrun, .rb_frame_err);
   srm_rb_model rb (.rb_clk, .rb_pin_data, .rb_int_data);
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   function automatic logic [20:0] skip_of(input logic [1:0] s);
      return s == 2'h0 ? SK0 : s == 2'h1 ? SK1 : SK2;
   endfunction
   // bounded so a lost word cannot hang the run
   task automatic drain(input int want);
      ndone = 0;
      chk_en = 1'b1;
      for (int i = 0; i < 100 && ndone < want; i++) begin
         tick(1);
         if (check_done === 1'b1) ndone++;
      end
      chk_en = 1'b0;
      tick(3);
   endtask
   task automatic clear();
      reconfig = 1'b1;
      tick(1);
      reconfig = 1'b0;
      tick(8);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // **********
   // sequence
   // **********
   initial begin
      tick(16);
      `CHK(global_output_float, 1'b1)
      `CHK(check_count, CHK_CNT_RST)
      rstn = 1'b1;
      tick(4);
      `CHK(global_output_float, 1'b1)
      cfg_done = 1'b1;
      tick(8);
      `CHK(global_output_float, 1'b0)
      $display("test reset done");
      foreach (rows[r]) begin
         dev_size = rows[r].size;
         rb_src_sel = rows[r].sel;
         exp_crc = rows[r].exp;
         rb.send_frame(skip_of(rows[r].size), rows[r].crc, 1'b0, rows[r].sel);
         drain(1);
         `CHK(crc_last, rows[r].crc)
         `CHK(upset_alarm, rows[r].alarm)
         `CHK(check_count, 8'(r + 1))
         clear();
         `CHK(upset_alarm, 1'b0)
      end
      `CHK(rb_overrun, 1'b0)
      `CHK(rb_frame_err, 1'b0)
      `CHK(cmp_fault, 1'b0)
      $display("test rows done");
      rb_src_sel = 1'b0;
      dev_size = 2'h0;
      exp_crc = 11'h108;
      for (int i = 0; i < 10; i++) rb.send_frame(SK0, 11'h100 + 11'(i), 1'b0, 1'b0);
      drain(10);
      `CHK(ndone, 9)
      `CHK(crc_last, 11'h108)
      `CHK(upset_alarm, 1'b1)
      `CHK(rb_overrun, 1'b1)
      `CHK(cmp_fault, 1'b0)
      clear();
      rb.send_frame(SK0, 11'h3C5, 1'b1, 1'b0);
      exp_crc = 11'h3C5;
      drain(1);
      `CHK(rb_frame_err, 1'b1)
      `CHK(crc_last, 11'h3C5)
      `CHK(upset_alarm, 1'b0)
      $display("test stream done");
      float_en = 1'b1;
      for (int i = 0; i < N_DUP; i++) begin
         dup_copy[i] = 1'b1;
         tick(2);
         `CHK(upset_status, 1'b1)
         `CHK(global_output_float, 1'b1)
         dup_copy[i] = 1'b0;
         clear();
         `CHK(upset_status, 1'b0)
      end
      float_en = 1'b0;
      dup_copy = 4'h5;
      tick(3);
      `CHK(upset_status, 1'b1)
      `CHK(global_output_float, 1'b0)
      $display("test duplicate done");
      final_report();
   end
   initial begin
      #200000;
      fails++;
      final_report();
   end
endmodule
bind srm_monitor srm_chk u_chk (.core_clk, .rstn, .exp_crc, .reconfig, .cfg_done, .float_en,
   .dup_primary, .dup_copy, .upset_alarm, .upset_status, .global_output_float, .check_done,
   .crc_last, .check_count);

// >>> tb/srm_assertions.sv
`timescale 1ns/1ns
module srm_chk
   import srm_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control
   input wire logic [CRC_W-1:0] exp_crc,
   input wire logic reconfig,
   input wire logic cfg_done,
   input wire logic float_en,
   input wire logic [N_DUP-1:0] dup_primary,
   input wire logic [N_DUP-1:0] dup_copy,
   // status
   input wire logic upset_alarm,
   input wire logic upset_status,
   input wire logic global_output_float,
   input wire logic check_done,
   input wire logic [CRC_W-1:0] crc_last,
   input wire logic [7:0] check_count
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // set once loading is reported; reconfig restarts the wait
   logic seen_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         seen_r <= 1'b0;
      end else begin
         seen_r <= (seen_r | cfg_done) & ~reconfig;
      end
   end
   sequence s_cfg_held;
      (cfg_done && !float_en && !reconfig) [*8];
   endsequence
   // **********
   // properties
   // **********
   AST_CNT_STEP: assert property (check_done |-> check_count == $past(check_count) + 8'h01)
      else $error("compare count did not step");
   AST_MISMATCH: assert property (check_done && ($past(crc_last) != $past(exp_crc, 2)) |-> upset_alarm)
      else $error("mismatch without alarm");
   AST_ALARM_CAUSE: assert property ($rose(upset_alarm) |-> check_done)
      else $error("alarm rose outside a compare");
   AST_ALARM_HOLD: assert property (upset_alarm && !reconfig |=> upset_alarm)
      else $error("alarm dropped without reconfig");
   AST_STATUS_SET: assert property ((dup_primary != dup_copy) && !reconfig |=> upset_status)
      else $error("pair difference not flagged");
   AST_STATUS_HOLD: assert property (upset_status && !reconfig |=> upset_status)
      else $error("status dropped without reconfig");
   AST_FLOAT_UPSET: assert property (float_en && upset_status |=> global_output_float)
      else $error("upset did not float outputs");
   AST_FLOAT_LOAD: assert property (!seen_r |=> global_output_float)
      else $error("outputs live before load");
   AST_RELEASE: assert property (s_cfg_held |-> !global_output_float)
      else $error("outputs not released");
endmodule

// >>> tb/srm_rb_model.sv
`timescale 1ns/1ns
module srm_rb_model
   import srm_pkg::*;
(
   // readback link
   output logic rb_clk,
   output logic rb_pin_data,
   output logic rb_int_data
);
   logic use_int;
   initial begin
      rb_clk = 1'b0;
      rb_pin_data = 1'b0;
      rb_int_data = 1'b1;
      use_int = 1'b0;
   end
   // unused source carries the inverse so a wrong pick shows
   task automatic put_bit(input logic b);
      rb_pin_data = use_int ? ~b : b;
      rb_int_data = use_int ? b : ~b;
      #3 rb_clk = 1'b1;
      #3 rb_clk = 1'b0;
   endtask
   // noise in front and zeros behind feed the link synchronisers
   task automatic send_frame(input logic [20:0] n, input logic [CRC_W-1:0] crc,
      input logic t0, input logic sel);
      logic [PRE_W-1:0] p;
      p = PREAMBLE;
      use_int = sel;
      for (int i = 0; i < 5; i++) put_bit(i != 4);
      for (int i = PRE_W - 1; i >= 0; i--) put_bit(p[i]);
      // fixed data stands for a configuration without lut_backed_ram contents
      for (int i = 0; i < n; i++) put_bit(i % 8 != 5);
      put_bit(t0);
      for (int i = CRC_W - 1; i >= 0; i--) put_bit(crc[i]);
      for (int i = 0; i < 4; i++) put_bit(1'b0);
      rb_pin_data = ~rb_pin_data;
      rb_int_data = ~rb_int_data;
   endtask
endmodule
